//--- hw/irig_b_time_code_receiver.sv
// Time code receiver: symbol decoder, frame assembler and time output.
// Assumes the mark level arrives synchronous to clk_in; in AM mode an
// external demodulator delivers mark as high, same as the DC line.
`timescale 1ns/1ps
module irig_b_time_code_receiver #(
  // Symbol length in clock cycles; benches shorten it to keep runs brief
  parameter int unsigned SYM_CYC = irig_rx_pkg::SYMBOL_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Line and mode
  input wire logic dc_line_in,
  input wire logic am_mark_in,
  input wire logic am_mode_in,
  // Host year, two BCD digits
  input wire logic [7:0] host_year_bcd_in,
  // Decoded time output
  output logic time_valid_out,
  input wire logic time_ready_in,
  output logic [11:0] year_out,
  output logic [8:0] day_out,
  output logic [4:0] hour_out,
  output logic [5:0] minute_out,
  output logic [5:0] second_out,
  // Status
  output logic frame_error_out,
  output logic fifo_full_out
);
  // ----------------------------------------
  // Symbol timing
  // ----------------------------------------
  // Both families carry the same pulse-width code after demodulation
  wire logic line = am_mode_in ? am_mark_in : dc_line_in;
  logic line_q;
  logic [23:0] mark_cnt;
  logic [23:0] gap_cnt;
  wire logic rise = line && !line_q;
  wire logic fall = !line && line_q;
  localparam logic [23:0] THR_ZERO_ONE = 24'(SYM_CYC * irig_rx_pkg::THR_ZERO_ONE_PCT / 100);
  localparam logic [23:0] THR_ONE_PI = 24'(SYM_CYC * irig_rx_pkg::THR_ONE_PI_PCT / 100);
  localparam logic [23:0] MAX_MARK = 24'(SYM_CYC * irig_rx_pkg::MAX_MARK_PCT / 100);
  localparam logic [23:0] MAX_GAP = 24'(SYM_CYC * 2);
  wire logic sym_bad = (mark_cnt >= MAX_MARK);
  wire logic timeout = (gap_cnt >= MAX_GAP);
  irig_rx_pkg::sym_t sym;
  assign sym = (mark_cnt < THR_ZERO_ONE) ? irig_rx_pkg::SYM_ZERO :
               (mark_cnt < THR_ONE_PI) ? irig_rx_pkg::SYM_ONE :
               irig_rx_pkg::SYM_PI;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      line_q <= 1'b0;
      mark_cnt <= '0;
      gap_cnt <= '0;
    end else begin
      line_q <= line;
      mark_cnt <= rise ? 24'h000001 : (line && !sym_bad) ? mark_cnt + 24'h000001 : mark_cnt;
      gap_cnt <= rise ? '0 : timeout ? gap_cnt : gap_cnt + 24'h000001;
    end
  end
  // ----------------------------------------
  // Frame assembly
  // ----------------------------------------
  irig_rx_pkg::rx_state_t state;
  irig_rx_pkg::rx_state_t next_state;
  logic [6:0] pos;
  logic [99:0] bits;
  logic [99:0] pis;
  logic frame_err;
  wire logic sym_done = fall && !sym_bad;
  wire logic is_pi = (sym == irig_rx_pkg::SYM_PI);
  wire logic frame_end = sym_done && (state == irig_rx_pkg::ST_FRAME) && (pos == irig_rx_pkg::LAST_POS);
  always_comb begin
    next_state = state;
    case (state)
      irig_rx_pkg::ST_HUNT: begin
        if (sym_done && is_pi) begin
          next_state = irig_rx_pkg::ST_ARMED;
        end
      end
      irig_rx_pkg::ST_ARMED: begin
        if (sym_done) begin
          next_state = is_pi ? irig_rx_pkg::ST_FRAME : irig_rx_pkg::ST_HUNT;
        end
      end
      irig_rx_pkg::ST_FRAME: begin
        if (frame_end) begin
          next_state = irig_rx_pkg::ST_ARMED;
        end
      end
      default: next_state = irig_rx_pkg::ST_HUNT;
    endcase
    if (timeout || (fall && sym_bad)) begin
      next_state = irig_rx_pkg::ST_HUNT;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= irig_rx_pkg::ST_HUNT;
      pos <= '0;
      bits <= '0;
      pis <= '0;
    end else begin
      state <= next_state;
      if (state == irig_rx_pkg::ST_ARMED && next_state == irig_rx_pkg::ST_FRAME) begin
        pos <= 7'h01;
        bits <= '0;
        pis <= 100'h1;
      end else if (sym_done && state == irig_rx_pkg::ST_FRAME && pos < irig_rx_pkg::FRAME_LEN) begin
        bits[pos] <= (sym == irig_rx_pkg::SYM_ONE);
        pis[pos] <= is_pi;
        pos <= pos + 7'h01;
      end
    end
  end
  // ----------------------------------------
  // Field extraction and checks
  // ----------------------------------------
  // Only BCD time of day, day of year and year are used; control and binary seconds dropped
  logic [99:0] fb;
  logic [99:0] fp;
  always_comb begin
    fb = bits;
    fp = pis;
    fb[irig_rx_pkg::LAST_POS] = 1'b0;
    fp[irig_rx_pkg::LAST_POS] = sym_done && is_pi;
  end
  wire logic [3:0] sec_u = fb[4:1];
  wire logic [3:0] sec_t = {1'b0, fb[8:6]};
  wire logic [3:0] min_u = fb[13:10];
  wire logic [3:0] min_t = {1'b0, fb[17:15]};
  wire logic [3:0] hr_u = fb[23:20];
  wire logic [3:0] hr_t = {2'b00, fb[26:25]};
  wire logic [3:0] day_u = fb[33:30];
  wire logic [3:0] day_t = fb[38:35];
  wire logic [3:0] day_h = {2'b00, fb[41:40]};
  wire logic [3:0] yr_u = fb[53:50];
  wire logic [3:0] yr_t = fb[58:55];
  // Digits widened to each field's width before the multiply; only day_b is wide enough never to wrap
  wire logic [5:0] sec_b = 6'(sec_t) * 6'h0a + 6'(sec_u);
  wire logic [5:0] min_b = 6'(min_t) * 6'h0a + 6'(min_u);
  wire logic [4:0] hr_b = 5'(hr_t) * 5'h0a + 5'(hr_u);
  wire logic [8:0] day_b = 9'(day_h) * 9'h064 + 9'(day_t) * 9'h00a + 9'(day_u);
  // Host year used when the frame sends zero
  wire logic yr_none = (yr_u == 4'h0) && (yr_t == 4'h0);
  wire logic [3:0] y_u = yr_none ? host_year_bcd_in[3:0] : yr_u;
  wire logic [3:0] y_t = yr_none ? host_year_bcd_in[7:4] : yr_t;
  wire logic [6:0] yr_b = 7'(y_t) * 7'h0a + 7'(y_u);
  wire logic [11:0] full_year = irig_rx_pkg::CENTURY + 12'(yr_b);
  // Leap test on 2000-2099: divisible by four
  wire logic leap = (yr_b[1:0] == 2'b00);
  wire logic digits_ok = (sec_u < 4'ha) && (min_u < 4'ha) && (hr_u < 4'ha) && (day_u < 4'ha) &&
                         (day_t < 4'ha) && (y_u < 4'ha) && (y_t < 4'ha);
  wire logic range_ok = (sec_b <= 6'h3b) && (min_b <= 6'h3b) && (hr_b <= 5'h17) &&
                        (day_b != 9'h000) && (day_b <= (leap ? 9'h16e : 9'h16d)) &&
                        (yr_b != 7'h00) && (yr_b <= 7'h63);
  logic [99:0] pi_expect;
  genvar gi;
  generate
    for (gi = 0; gi < 100; gi++) begin : g_pi
      assign pi_expect[gi] = (gi % 10 == 9) || (gi == 0);
    end
  endgenerate
  wire logic pis_ok = (fp == pi_expect);
  wire logic frame_ok = digits_ok && range_ok && pis_ok;
  // ----------------------------------------
  // Output FIFO and flags
  // ----------------------------------------
  logic push;
  logic [irig_rx_pkg::TIME_W-1:0] push_data;
  wire logic fifo_ready;
  wire logic [irig_rx_pkg::TIME_W-1:0] pop_data;
  wire logic pop_valid;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      push <= 1'b0;
      push_data <= '0;
      frame_err <= 1'b0;
    end else begin
      if (push && fifo_ready) begin
        push <= 1'b0;
      end
      if (frame_end && frame_ok && !(push && !fifo_ready)) begin
        push <= 1'b1;
        push_data <= {full_year, day_b, hr_b, min_b, sec_b};
      end
      if (frame_end) begin
        frame_err <= !frame_ok || (push && !fifo_ready);
      end
    end
  end
  irig_fifo #(.WIDTH(irig_rx_pkg::TIME_W), .DEPTH(16)) irig_fifo_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data),
    .out_valid_out(pop_valid),
    .out_ready_in(time_ready_in && !time_valid_out),
    .out_data_out(pop_data)
  );
  // Output stage register: holds one entry until taken
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      time_valid_out <= 1'b0;
      {year_out, day_out, hour_out, minute_out, second_out} <= '0;
      frame_error_out <= 1'b0;
      fifo_full_out <= 1'b0;
    end else begin
      frame_error_out <= frame_err;
      fifo_full_out <= !fifo_ready;
      if (time_valid_out && time_ready_in) begin
        time_valid_out <= 1'b0;
      end else if (!time_valid_out && pop_valid && time_ready_in) begin
        time_valid_out <= 1'b1;
        {year_out, day_out, hour_out, minute_out, second_out} <= pop_data;
      end
    end
  end
endmodule

//--- hw/irig_fifo.sv
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module irig_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic do_wr = in_valid_in && !full;
  wire logic do_rd = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- hw/irig_rx_pkg.sv
// Constants for the time code receiver.
// Assumes a 100 MHz system clock and a decoded mark/space level input.
package irig_rx_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SYMBOL_MS = 10;
  localparam int unsigned SYMBOL_CYC = CLK_HZ / 1000 * SYMBOL_MS;
  // Width thresholds between 20/50 and 50/80 percent, and an upper bound
  localparam int unsigned THR_ZERO_ONE_PCT = 35;
  localparam int unsigned THR_ONE_PI_PCT = 65;
  localparam int unsigned MAX_MARK_PCT = 95;
  localparam logic [23:0] THR_ZERO_ONE = 24'(SYMBOL_CYC * THR_ZERO_ONE_PCT / 100);
  localparam logic [23:0] THR_ONE_PI = 24'(SYMBOL_CYC * THR_ONE_PI_PCT / 100);
  localparam logic [23:0] MAX_MARK = 24'(SYMBOL_CYC * MAX_MARK_PCT / 100);
  localparam logic [23:0] MAX_GAP = 24'(SYMBOL_CYC * 2);
  localparam logic [6:0] FRAME_LEN = 7'h64;
  localparam logic [6:0] LAST_POS = 7'h63;
  localparam logic [11:0] CENTURY = 12'h7d0;
  localparam int unsigned TIME_W = 38;
  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_ONE = 2'b01,
    SYM_PI = 2'b10
  } sym_t;
  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_ARMED = 2'b01,
    ST_FRAME = 2'b10
  } rx_state_t;
endpackage

//--- sim/irig_line_source.sv
// Time code source model: one pulse-width symbol per start request.
// Assumes a period far shorter than real symbols so runs stay short.
`timescale 1ns/1ps
module irig_line_source #(
  parameter int PERIOD = 200
) (
  // Clock
  input wire logic clk_in,
  // Request
  input wire logic start_in,
  input wire logic [1:0] kind_in,
  // Line
  output logic line_out,
  output logic busy_out
);
  int cnt = 0;
  int width = 0;
  always_ff @(posedge clk_in) begin
    if (start_in && cnt == 0) begin
      cnt <= PERIOD;
      width <= (kind_in == 2'h0) ? PERIOD / 5 : (kind_in == 2'h1) ? PERIOD / 2 : PERIOD * 4 / 5;
    end else if (cnt != 0) cnt <= cnt - 1;
  end
  // Mark is high at the start of the period, space low afterwards
  assign line_out = (cnt > PERIOD - width);
  assign busy_out = (cnt != 0);
endmodule

//--- sim/irig_rx_checker.sv
// Checker on the receiver's ports: output handshake and decoded ranges.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module irig_rx_checker #(
  parameter int unsigned SYM_CYC = irig_rx_pkg::SYMBOL_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Observed ports
  input wire logic time_valid_out,
  input wire logic time_ready_in,
  input wire logic [11:0] year_out,
  input wire logic [8:0] day_out,
  input wire logic [4:0] hour_out,
  input wire logic [5:0] minute_out,
  input wire logic [5:0] second_out,
  input wire logic frame_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Two identifiers must pass before any frame can start
  localparam logic [20:0] MIN_FIRST = 21'(SYM_CYC * 13 / 10);
  // Cycles since reset release, saturating
  logic [20:0] up_cnt;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) up_cnt <= 21'h0;
    else if (up_cnt != 21'h1fffff) up_cnt <= up_cnt + 21'h1;
  end
  chk_time_holds: assert property (time_valid_out && !time_ready_in |=> time_valid_out && $stable(year_out)
    && $stable(day_out) && $stable(hour_out) && $stable(minute_out) && $stable(second_out))
    else $error("time outputs moved while waiting");
  chk_valid_drops: assert property (time_valid_out && time_ready_in |=> !time_valid_out)
    else $error("valid stayed after acceptance");
  chk_load_ready: assert property ($rose(time_valid_out) |-> $past(time_ready_in))
    else $error("time loaded without ready");
  chk_year_range: assert property (time_valid_out |-> year_out >= 12'h7d1 && year_out <= 12'h833)
    else $error("year outside range");
  chk_day_range: assert property (time_valid_out |-> day_out >= 9'h1 && day_out <= 9'h16e)
    else $error("day outside range");
  chk_leap_day: assert property (time_valid_out && day_out == 9'h16e |-> year_out[1:0] == 2'h0)
    else $error("day 366 in ordinary year");
  chk_hms_range: assert property (time_valid_out |-> hour_out <= 5'h17 && minute_out <= 6'h3b
    && second_out <= 6'h3b)
    else $error("time field outside range");
  chk_error_once: assert property ($changed(frame_error_out) |=> $stable(frame_error_out) [*8])
    else $error("error flag changed twice quickly");
  chk_frame_time: assert property ($rose(time_valid_out) |-> up_cnt >= MIN_FIRST)
    else $error("time appeared before a frame could end");
endmodule
bind irig_b_time_code_receiver irig_rx_checker #(.SYM_CYC(SYM_CYC)) irig_rx_checker_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .time_valid_out(time_valid_out), .time_ready_in(time_ready_in), .year_out(year_out), .day_out(day_out),
  .hour_out(hour_out), .minute_out(minute_out), .second_out(second_out), .frame_error_out(frame_error_out));

//--- sim/tb_irig_b_time_code_receiver.sv
// Bench: random symbols in both modes, then directed frames with and without year.
// Assumes the source model and a 100 MHz clock.
`timescale 1ns/1ps
module tb_irig_b_time_code_receiver;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic am_mode_in = 1'b0;
  logic time_ready_in = 1'b0;
  logic [7:0] host_year_bcd_in = 8'h00;
  logic noise = 1'b0;
  logic start = 1'b0;
  logic [1:0] kind = 2'h0;
  logic src_line, busy, dc_line_in, am_mark_in, time_valid_out, frame_error_out, fifo_full_out;
  logic [11:0] year_out;
  logic [8:0] day_out;
  logic [4:0] hour_out;
  logic [5:0] minute_out, second_out;
  logic [38:0] notes[$];
  logic [38:0] exp_t;
  logic [31:0] seed = 32'h0000e5ea;
  localparam int SYM = 100;
  localparam logic [7:0] HOST_YR = 8'h24;
  int err_count = 0;
  int n_tests = 0;
  always #5 clk_in = ~clk_in;
  // Unselected line carries noise, the selected one the source
  assign dc_line_in = am_mode_in ? noise : src_line;
  assign am_mark_in = am_mode_in ? src_line : noise;
  irig_line_source #(.PERIOD(SYM)) irig_line_source_inst (.clk_in(clk_in), .start_in(start), .kind_in(kind),
    .line_out(src_line), .busy_out(busy));
  irig_b_time_code_receiver #(.SYM_CYC(SYM)) irig_b_time_code_receiver_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .dc_line_in(dc_line_in), .am_mark_in(am_mark_in), .am_mode_in(am_mode_in), .host_year_bcd_in(host_year_bcd_in),
    .time_valid_out(time_valid_out), .time_ready_in(time_ready_in), .year_out(year_out), .day_out(day_out),
    .hour_out(hour_out), .minute_out(minute_out), .second_out(second_out), .frame_error_out(frame_error_out),
    .fifo_full_out(fifo_full_out));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Each accepted time takes the oldest note; with no note bit 38 forces a mismatch
  always @(posedge clk_in) begin
    if (rst_n_in && time_valid_out === 1'b1 && time_ready_in) begin
      exp_t = (notes.size() != 0) ? notes.pop_front() : 39'h4000000000;
      check(39'({year_out, day_out, hour_out, minute_out, second_out}), exp_t);
    end
  end
  // One symbol from the source model, bounded wait for its end
  task automatic send_sym(input logic [1:0] k);
    int w;
    kind <= k;
    start <= 1'b1;
    @(negedge clk_in);
    start <= 1'b0;
    w = 0;
    while (busy && w < 400) begin
      @(negedge clk_in);
      w++;
    end
    if (w >= 400) begin
      check(39'h1, 39'h0);
      finish_test();
    end
  endtask
  // One frame, positions 0 to 99; exp is noted only for a frame that must be kept
  task automatic send_frame(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h, input logic [11:0] d,
                            input logic [7:0] y, input logic ok, input logic [38:0] exp);
    logic [99:0] b;
    b = '0;
    b[4:1] = s[3:0];
    b[8:6] = s[6:4];
    b[13:10] = m[3:0];
    b[17:15] = m[6:4];
    b[23:20] = h[3:0];
    b[26:25] = h[5:4];
    b[33:30] = d[3:0];
    b[38:35] = d[7:4];
    b[41:40] = d[9:8];
    b[53:50] = y[3:0];
    b[58:55] = y[7:4];
    b[68:60] = seed[8:0];
    b[78:70] = seed[17:9];
    b[88:80] = seed[26:18];
    b[97:90] = seed[31:24];
    if (ok) notes.push_back(exp);
    for (int p = 0; p < 100; p++) begin
      time_ready_in <= seed[3];
      send_sym((p == 0 || p % 10 == 9) ? 2'h2 : {1'b0, b[p]});
    end
    check(39'(frame_error_out), 39'(!ok));
  endtask
  always @(negedge clk_in) begin
    seed = xs(seed);
    noise <= seed[0];
  end
  initial begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) rst_n_in <= 1'b1;
    @(posedge clk_in) #1;
    check(39'({time_valid_out, frame_error_out, fifo_full_out, year_out, day_out}), 39'h0);
    @(negedge clk_in);
    // Random symbols in both modes; none of them may yield a kept time
    for (int i = 0; i < 200; i++) begin
      am_mode_in <= 1'((i / 50) % 2);
      time_ready_in <= seed[3];
      host_year_bcd_in <= {4'(seed[7:4] % 10), 4'(seed[11:8] % 10)};
      send_sym(2'(seed[20:13] % 3));
    end
    // A quiet line sends the receiver back to hunting
    repeat (3 * SYM) @(negedge clk_in);
    check(39'({time_valid_out, fifo_full_out}), 39'h0);
    check(39'(notes.size()), 39'h0);
    am_mode_in <= 1'b0;
    host_year_bcd_in <= HOST_YR;
    send_sym(2'h2);
    send_frame(8'h59, 8'h07, 8'h23, 12'h365, 8'h99, 1'b1, 39'({12'h833, 9'h16d, 5'h17, 6'h07, 6'h3b}));
    send_frame(8'h00, 8'h00, 8'h00, 12'h366, 8'h00, 1'b1, 39'({12'h7e8, 9'h16e, 5'h00, 6'h00, 6'h00}));
    am_mode_in <= 1'b1;
    send_frame(8'h30, 8'h15, 8'h24, 12'h100, 8'h07, 1'b0, 39'h0);
    send_frame(8'h31, 8'h45, 8'h12, 12'h001, 8'h07, 1'b1, 39'({12'h7d7, 9'h001, 5'h0c, 6'h2d, 6'h1f}));
    time_ready_in <= 1'b1;
    repeat (20) @(negedge clk_in);
    check(39'({time_valid_out, frame_error_out, fifo_full_out}), 39'h0);
    check(39'(notes.size()), 39'h0);
    finish_test();
  end
endmodule
